// >>> global_config_register_access.sv
// Index/data access logic for the chip-level configuration registers
`timescale 1ns/1ns
// Operation
// - Global registers occupy indices 0x00 through 0x2f of the configuration space.
// - All eight index bits are decoded, so no upper-bit aliasing occurs.
// - Unimplemented indices and bits ignore writes and read as zero.
// - A write to the index port is latched as the current register selection.
// - Data port accesses go to the currently selected register.
// - Ports act on these registers only while configuration mode is active.
// - Bits written to the configuration-control register at index 0x02 clear themselves after acting.
module global_config_register_access (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic config_mode,
    input wire logic index_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] wdata,
    output logic [7:0] index_r,
    output logic [7:0] rdata_r,
    output logic rvalid_r,
    output logic [7:0] cfg_ctrl_pulse_r
);
    ////////////////////////////////////////////////////////////////////////
    // Offset compare stays valid if the window ever moves off index zero
    function automatic logic in_global(input logic [7:0] idx);
        logic [7:0] offset;
        offset = idx - gcfg_pkg::GLOBAL_FIRST;
        in_global = offset <= (gcfg_pkg::GLOBAL_LAST - gcfg_pkg::GLOBAL_FIRST);
    endfunction : in_global

    function automatic logic [7:0] bit_mask(input logic [7:0] idx);
        if (!in_global(idx)) begin
            bit_mask = 8'h00;
        end else if (!gcfg_pkg::IMPL_MAP[idx[5:0]]) begin
            bit_mask = 8'h00;
        end else if (idx == gcfg_pkg::IDX_CFG_CTRL) begin
            bit_mask = gcfg_pkg::CFG_CTRL_MASK;
        end else begin
            bit_mask = 8'h00;
        end
    endfunction : bit_mask

    ////////////////////////////////////////////////////////////////////////
    wire logic [7:0] sel_mask;
    wire logic is_ctrl;
    wire logic data_wr_ok;
    wire logic data_rd_ok;
    wire logic ctrl_write;
    wire logic [7:0] index_nxt;
    wire logic [7:0] pulse_nxt;
    wire logic [7:0] rdata_nxt;
    wire logic rvalid_nxt;

    assign sel_mask = bit_mask(index_r);
    assign is_ctrl = (index_r == gcfg_pkg::IDX_CFG_CTRL);
    assign data_wr_ok = config_mode && data_wr;
    assign data_rd_ok = config_mode && data_rd;
    assign ctrl_write = data_wr_ok && is_ctrl;
    // Leaving config mode drops the selection so a later session starts clean
    assign index_nxt = !config_mode ? gcfg_pkg::IDX_RESET : (index_wr ? wdata : index_r);
    // No global register keeps readable state here, so reads give zero
    assign rdata_nxt = data_rd_ok ? (8'h00 & sel_mask) : gcfg_pkg::DATA_RESET;
    assign rvalid_nxt = data_rd_ok;

    // Control register is write-only: one-cycle action pulse, never stored
    for (genvar b = 0; b < 8; b++) begin : g_pulse_bit
        assign pulse_nxt[b] = ctrl_write && wdata[b] && sel_mask[b];
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            index_r <= gcfg_pkg::IDX_RESET;
        end else begin
            index_r <= index_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdata_r <= gcfg_pkg::DATA_RESET;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rvalid_r <= gcfg_pkg::VALID_RESET;
        end else begin
            rvalid_r <= rvalid_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            cfg_ctrl_pulse_r <= gcfg_pkg::PULSE_RESET;
        end else begin
            cfg_ctrl_pulse_r <= pulse_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request shapes shared by the checks below
    sequence sel_write_s;
        config_mode && index_wr;
    endsequence

    sequence sel_idle_s;
        config_mode && !index_wr ##1 config_mode;
    endsequence

    sequence ctrl_write_s;
        config_mode && data_wr && index_r == gcfg_pkg::IDX_CFG_CTRL;
    endsequence

    sequence pulse_then_idle_s;
        cfg_ctrl_pulse_r != 8'h00 ##1 !(config_mode && data_wr);
    endsequence

    sequence read_req_s;
        config_mode && data_rd;
    endsequence

    sequence mode_off_s;
        !config_mode;
    endsequence

    sequence dead_write_s;
        config_mode && data_wr && bit_mask(index_r) == 8'h00;
    endsequence

    index_latch_a: assert property (@(posedge clock) disable iff (!reset_n)
        sel_write_s
        |=> index_r == $past(wdata))
        else $error("index not latched");

    index_full_a: assert property (@(posedge clock) disable iff (!reset_n)
        sel_write_s
        |=> index_r[7:6] == $past(wdata[7:6]))
        else $error("upper index bits lost");

    index_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        sel_idle_s
        |-> $stable(index_r))
        else $error("index changed");

    mode_exit_a: assert property (@(posedge clock) disable iff (!reset_n)
        mode_off_s
        |=> index_r == gcfg_pkg::IDX_RESET)
        else $error("index kept outside config mode");

    mode_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
        mode_off_s ##1 mode_off_s
        |=> $stable(index_r))
        else $error("index moved outside config mode");

    mode_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
        mode_off_s
        |=> !rvalid_r && cfg_ctrl_pulse_r == 8'h00)
        else $error("access outside config mode");

    read_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
        rvalid_r
        |-> rdata_r == 8'h00)
        else $error("unimplemented read nonzero");

    read_valid_a: assert property (@(posedge clock) disable iff (!reset_n)
        read_req_s
        |=> rvalid_r)
        else $error("read not answered");

    read_once_a: assert property (@(posedge clock) disable iff (!reset_n)
        read_req_s ##1 !(config_mode && data_rd)
        |=> !rvalid_r)
        else $error("read answer stretched");

    valid_source_a: assert property (@(posedge clock) disable iff (!reset_n)
        !(config_mode && data_rd)
        |=> !rvalid_r)
        else $error("answer without read");

    ctrl_route_a: assert property (@(posedge clock) disable iff (!reset_n)
        ctrl_write_s
        |=> cfg_ctrl_pulse_r == ($past(wdata) & gcfg_pkg::CFG_CTRL_MASK))
        else $error("control write lost");

    ctrl_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
        pulse_then_idle_s
        |=> cfg_ctrl_pulse_r == 8'h00)
        else $error("control bits not cleared");

    pulse_source_a: assert property (@(posedge clock) disable iff (!reset_n)
        !(config_mode && data_wr)
        |=> cfg_ctrl_pulse_r == 8'h00)
        else $error("control pulse without write");

    other_idx_a: assert property (@(posedge clock) disable iff (!reset_n)
        index_r != gcfg_pkg::IDX_CFG_CTRL
        |=> cfg_ctrl_pulse_r == 8'h00)
        else $error("aliased write");

    dead_write_a: assert property (@(posedge clock) disable iff (!reset_n)
        dead_write_s
        |=> cfg_ctrl_pulse_r == 8'h00)
        else $error("unimplemented write acted");

    range_limit_a: assert property (@(posedge clock) disable iff (!reset_n)
        config_mode && data_wr && index_r > gcfg_pkg::GLOBAL_LAST
        |=> cfg_ctrl_pulse_r == 8'h00)
        else $error("write above global range acted");

    pulse_mask_a: assert property (@(posedge clock) disable iff (!reset_n)
        (cfg_ctrl_pulse_r & ~gcfg_pkg::CFG_CTRL_MASK) == 8'h00)
        else $error("unimplemented control bit set");

    // Runs without disable so the cleared state itself is checked
    reset_clear_a: assert property (@(posedge clock)
        !reset_n
        |=> index_r == gcfg_pkg::IDX_RESET && rvalid_r == gcfg_pkg::VALID_RESET
            && rdata_r == gcfg_pkg::DATA_RESET && cfg_ctrl_pulse_r == gcfg_pkg::PULSE_RESET)
        else $error("outputs not cleared by reset");
endmodule : global_config_register_access

// >>> gcfg_pkg.sv
// Package with the constants for the global configuration access block
package gcfg_pkg;
    localparam logic [7:0] GLOBAL_FIRST = 8'h00;
    localparam logic [7:0] GLOBAL_LAST = 8'h2f;
    localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
    localparam logic [7:0] IDX_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] PULSE_RESET = 8'h00;
    localparam logic VALID_RESET = 1'b0;
    // Implemented global registers, one bit per index 0x00..0x2f
    localparam logic [47:0] IMPL_MAP = 48'h0000_0000_0004;
    // Writable bit masks; arbitrary plain defaults, zero means unimplemented
    localparam logic [7:0] CFG_CTRL_MASK = 8'h03;
endpackage : gcfg_pkg

// >>> cfg_host.sv
// Host model for index and data port cycles
`timescale 1ns/1ns
module cfg_host (
    input wire logic clock,
    output logic index_wr,
    output logic data_wr,
    output logic data_rd,
    output logic [7:0] wdata
);
    initial {index_wr, data_wr, data_rd, wdata} = 11'h000;
    task automatic cyc(input logic [1:0] op, input logic [7:0] d);
        @(negedge clock);
        {index_wr, data_wr, data_rd, wdata} = {op == 2'h0, op == 2'h1, op == 2'h2, d};
        @(negedge clock);
        {index_wr, data_wr, data_rd, wdata} = {3'h0, ~d}; // Released bus never shows stale data
    endtask : cyc
endmodule : cfg_host

// >>> global_config_register_access_tb.sv
// Random self-checking bench for the config access block
`timescale 1ns/1ns
module global_config_register_access_tb;
    logic clock = 1'b0, reset_n = 1'b0, config_mode = 1'b0, index_wr, data_wr, data_rd, rvalid_r;
    logic [7:0] wdata, index_r, rdata_r, cfg_ctrl_pulse_r, d, e, idx = 8'h00;
    int mismatches = 0, total_checks = 0, op;
    always #4 clock = ~clock;
    cfg_host host (.clock(clock), .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata));
    global_config_register_access DUT (.clock(clock), .reset_n(reset_n), .config_mode(config_mode),
        .index_wr(index_wr), .data_wr(data_wr), .data_rd(data_rd), .wdata(wdata), .index_r(index_r),
        .rdata_r(rdata_r), .rvalid_r(rvalid_r), .cfg_ctrl_pulse_r(cfg_ctrl_pulse_r));
    wire [24:0] seen = {index_r, cfg_ctrl_pulse_r, rvalid_r, rdata_r};
    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    initial begin
        op = $urandom(15290);
        #24 reset_n = 1'b1;
        repeat (80) begin
            config_mode = ($urandom % 4) != 0;
            op = $urandom % 3;
            // Index picks 0x00/0x02/0x80/0x82 to expose aliasing
            d = 8'($urandom) & (op == 0 ? 8'h82 : 8'hff);
            host.cyc(2'(op), d);
            idx = config_mode ? (op == 0 ? d : idx) : gcfg_pkg::IDX_RESET;
            e = (config_mode && op == 1 && idx == gcfg_pkg::IDX_CFG_CTRL) ? d & gcfg_pkg::CFG_CTRL_MASK : 8'h00;
            chk(seen, {idx, e, config_mode && op == 2, 8'h00});
        end
        $display("random access test done");
        config_mode = 1'b1;
        host.cyc(2'h0, gcfg_pkg::IDX_CFG_CTRL);
        host.cyc(2'h1, 8'hff);
        chk(seen, {gcfg_pkg::IDX_CFG_CTRL, gcfg_pkg::CFG_CTRL_MASK, 1'b0, 8'h00});
        @(negedge clock);
        chk(seen, {gcfg_pkg::IDX_CFG_CTRL, 8'h00, 1'b0, 8'h00});
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        chk(seen, {gcfg_pkg::IDX_RESET, 8'h00, 1'b0, 8'h00});
        host.cyc(2'h1, 8'hff);
        chk(seen, {gcfg_pkg::IDX_RESET, 8'h00, 1'b0, 8'h00});
        $display("directed control and reset test done");
        stop_test();
    end
endmodule : global_config_register_access_tb
